/* File: logic/wrf_consts.svh */
// constants of the windowed integer register file
`ifndef WRF_CONSTS_SVH
`define WRF_CONSTS_SVH

`define WRF_GLOBALS        8
`define WRF_WIN_REGS       24
`define WRF_WIN_SLOTS      16
`define WRF_NWIN_DEFAULT   8
`define WRF_NWIN_MIN       2
`define WRF_NWIN_MAX       32
`define WRF_CWP_MSB        4
`define WRF_CWP_LSB        0
`define WRF_REG_IN_BASE    24
`define WRF_REG_LOCAL_BASE 16
`define WRF_REG_OUT_BASE   8
`define WRF_REG_CALL_LINK  15
`define WRF_REG_TRAP_PC    17
`define WRF_REG_TRAP_NPC   18
`define WRF_CWP_RESET      5'h00
`define WRF_WIM_RESET      32'h0000_0000
`define WRF_DATA_RESET     32'h0000_0000

`endif

/* File: logic/wrf_pkg.sv */
// types shared by the windowed integer register file
package wrf_pkg;

  typedef enum logic [2:0] {
    WOP_NONE,
    WOP_SAVE,
    WOP_RESTORE,
    WOP_RETURN_FROM_TRAP,
    WOP_TRAP,
    WOP_CALL
  } wrf_op_t;

  typedef enum logic {
    ST_IDLE,
    ST_TRAP_NPC
  } wrf_state_t;

  typedef struct packed {
    wrf_op_t     op;
    logic [31:0] pc;
    logic [31:0] next_program_counter;
  } wrf_cmd_t;

  typedef struct packed {
    logic        en;
    logic [4:0]  num;
    logic [31:0] data;
  } wrf_wr_t;

  typedef struct packed {
    logic        wimWe;
    logic        psrWe;
    logic [31:0] data;
  } wrf_ctl_t;

  typedef struct packed {
    logic overflow;
    logic underflow;
    logic busy;
  } wrf_evt_t;

endpackage

/* File: logic/wrf_index_map.sv */
// translation of register number and window pointer to a storage index
`timescale 1ns/1ps
`default_nettype none
`include "wrf_consts.svh"

module wrf_index_map #(
  parameter int NWIN = `WRF_NWIN_DEFAULT,
  parameter int PIW  = 8
) (
  input  wire logic [4:0]     num,  // register number 0..31
  input  wire logic [4:0]     current_window_pointer,  // window pointer used
  output logic      [PIW-1:0] idx   // storage index
);

  always_comb
  begin
    int win;
    int slot;
    win  = 0;
    slot = 0;
    if (num < 5'(`WRF_REG_OUT_BASE))
    begin
      // globals sit below every window, same storage for all
      slot = int'(num);
    end
    else if (num >= 5'(`WRF_REG_IN_BASE))
    begin
      win  = int'(current_window_pointer);
      slot = `WRF_GLOBALS + `WRF_GLOBALS + int'(num[2:0]);
    end
    else if (num >= 5'(`WRF_REG_LOCAL_BASE))
    begin
      // locals are private to the window
      win  = int'(current_window_pointer);
      slot = `WRF_GLOBALS + int'(num[2:0]);
    end
    else
    begin
      // outs are the ins of window cwp-1, wrapping to the top one
      win  = (current_window_pointer == 5'h00) ? NWIN - 1 : int'(current_window_pointer) - 1;
      slot = `WRF_GLOBALS + `WRF_GLOBALS + int'(num[2:0]);
    end
    if (num < 5'(`WRF_REG_OUT_BASE))
      idx = PIW'(slot);
    else
      idx = PIW'(win * `WRF_WIN_SLOTS + slot);
  end

endmodule
`default_nettype wire

/* File: logic/wrf_regfile.sv */
// windowed integer register file with window pointer and invalid mask
//
// Notes on behaviour
// - eight shared 32-bit globals; each window adds 16 more registers.
// - window count is a parameter 2..32, windows numbered 0 upward.
// - pointer picks the window; restore/return_from_trap increment, save decrements.
// - numbers 24-31 ins, 16-23 locals, 8-15 outs, 0-7 globals.
// - out o equals register o+16 after pointer minus one, wrapped.
// - in i equals register i-16 after pointer plus one, wrapped.
// - windows form a ring; top window adjoins window zero.
// - globals common to all windows; locals private to each window.
// - register zero reads zero; writing it changes nothing.
// - a call writes its own address into out register 15.
// - a trap stores pc and next pc into two locals of next window.
// - software-written invalid mask detects overflow and underflow.
// - every save checks for overflow before completing.
// - every restore checks for underflow before completing.
// - window pointer sits in bits 4..0 of the state register.
// - a trap decrements the window pointer like a save.
// - pointer arithmetic wraps modulo the window count.
// - save onto masked window overflows; restore or return_from_trap underflows.
`timescale 1ns/1ps
`default_nettype none
`include "wrf_consts.svh"

module wrf_regfile
  import wrf_pkg::*;
#(
  parameter int NWIN = `WRF_NWIN_DEFAULT
) (
  input  wire logic              ref_clk,   // processor clock
  input  wire logic              rst_n,     // synchronous reset
  input  wire logic [4:0]        rdNumA,    // first source number
  input  wire logic [4:0]        rdNumB,    // second source number
  input  wire wrf_pkg::wrf_wr_t  wrReq,     // destination write
  input  wire wrf_pkg::wrf_cmd_t cmd,       // window move, call, trap
  input  wire wrf_pkg::wrf_ctl_t ctl,       // mask and state writes
  output logic [31:0]            rdDataA,   // first source value
  output logic [31:0]            rdDataB,   // second source value
  output logic [31:0]            psrWord,   // state register window field
  output logic [31:0]            wimWord,   // invalid mask value
  output wrf_pkg::wrf_evt_t      evt        // trap pulses and busy
);
  import wrf_pkg::*;

  // ----------------------------------------------------------------
  // sizing
  // ----------------------------------------------------------------
  localparam int PHYS = `WRF_GLOBALS + `WRF_WIN_SLOTS * NWIN;
  localparam int PIW  = $clog2(PHYS);
  localparam int CW   = `WRF_CWP_MSB - `WRF_CWP_LSB + 1;
  localparam logic [31:0] WIM_IMPL =
    32'((64'h0000_0000_0000_0001 << NWIN) - 64'h0000_0000_0000_0001);

  function automatic logic [CW-1:0] wrapDec(input logic [CW-1:0] w);
    wrapDec = (w == '0) ? CW'(NWIN - 1) : w - 1'b1;
  endfunction

  function automatic logic [CW-1:0] wrapInc(input logic [CW-1:0] w);
    wrapInc = (w == CW'(NWIN - 1)) ? '0 : w + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]   mem [PHYS];
  logic [CW-1:0] cwp_r;
  logic [31:0]   wim_r;
  wrf_state_t    state_r;
  logic [31:0]   trapNpc_r;
  logic          ovf_r;
  logic          unf_r;
  logic          busy_r;
  logic [31:0]   rdA_r;
  logic [31:0]   rdB_r;

  logic [CW-1:0] cwpDec;
  logic [CW-1:0] cwpInc;
  logic          idle;
  logic          saveOk;
  logic          restOk;
  logic          isRest;

  assign cwpDec = wrapDec(cwp_r);
  assign cwpInc = wrapInc(cwp_r);
  assign idle   = (state_r == ST_IDLE);
  assign isRest = (cmd.op == WOP_RESTORE) || (cmd.op == WOP_RETURN_FROM_TRAP);
  assign saveOk = idle && (cmd.op == WOP_SAVE) && !wim_r[cwpDec];
  assign restOk = idle && isRest && !wim_r[cwpInc];

  // ----------------------------------------------------------------
  // write port selection
  // ----------------------------------------------------------------
  logic          wrEnSel;
  logic [4:0]    wrNumSel;
  logic [CW-1:0] wrCwpSel;
  logic [31:0]   wrDataSel;
  logic [PIW-1:0] wrIdx;
  logic [PIW-1:0] rdIdxA;
  logic [PIW-1:0] rdIdxB;

  // trap writes take the single port, so the next pc follows a cycle later
  always_comb
  begin
    wrEnSel   = 1'b0;
    wrNumSel  = 5'h00;
    wrCwpSel  = cwp_r;
    wrDataSel = wrReq.data;
    if (state_r == ST_TRAP_NPC)
    begin
      wrEnSel   = 1'b1;
      wrNumSel  = 5'(`WRF_REG_TRAP_NPC);
      wrDataSel = trapNpc_r;
    end
    else if (cmd.op == WOP_TRAP)
    begin
      wrEnSel   = 1'b1;
      wrNumSel  = 5'(`WRF_REG_TRAP_PC);
      wrCwpSel  = cwpDec;
      wrDataSel = cmd.pc;
    end
    else if (cmd.op == WOP_CALL)
    begin
      wrEnSel   = 1'b1;
      wrNumSel  = 5'(`WRF_REG_CALL_LINK);
      wrDataSel = cmd.pc;
    end
    else if (wrReq.en && wrReq.num != 5'h00)
    begin
      wrEnSel  = 1'b1;
      wrNumSel = wrReq.num;
    end
  end

  wrf_index_map #(.NWIN(NWIN), .PIW(PIW)) uMapWr (
    .num (wrNumSel),
    .current_window_pointer (wrCwpSel),
    .idx (wrIdx)
  );

  wrf_index_map #(.NWIN(NWIN), .PIW(PIW)) uMapA (
    .num (rdNumA),
    .current_window_pointer (cwp_r),
    .idx (rdIdxA)
  );

  wrf_index_map #(.NWIN(NWIN), .PIW(PIW)) uMapB (
    .num (rdNumB),
    .current_window_pointer (cwp_r),
    .idx (rdIdxB)
  );

  // ----------------------------------------------------------------
  // storage and read ports
  // ----------------------------------------------------------------
  // data storage has no reset; only the write port ever changes it
  always_ff @(posedge ref_clk)
  begin
    if (wrEnSel)
      mem[wrIdx] <= wrDataSel;
  end

  // reads return the value held before a same-cycle write
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rdA_r <= `WRF_DATA_RESET;
      rdB_r <= `WRF_DATA_RESET;
    end
    else
    begin
      rdA_r <= (rdNumA == 5'h00) ? 32'h0000_0000 : mem[rdIdxA];
      rdB_r <= (rdNumB == 5'h00) ? 32'h0000_0000 : mem[rdIdxB];
    end
  end

  // ----------------------------------------------------------------
  // window pointer and trap sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cwp_r <= `WRF_CWP_RESET;
    else if (saveOk || (idle && cmd.op == WOP_TRAP))
      cwp_r <= cwpDec;
    else if (restOk)
      cwp_r <= cwpInc;
    else if (idle && cmd.op == WOP_NONE && ctl.psrWe &&
             int'(ctl.data[`WRF_CWP_MSB:`WRF_CWP_LSB]) < NWIN)
      cwp_r <= ctl.data[`WRF_CWP_MSB:`WRF_CWP_LSB];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      trapNpc_r <= `WRF_DATA_RESET;
      busy_r    <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (cmd.op == WOP_TRAP)
          begin
            state_r   <= ST_TRAP_NPC;
            trapNpc_r <= cmd.next_program_counter;
            busy_r    <= 1'b1;
          end
        end
        ST_TRAP_NPC:
        begin
          state_r <= ST_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // invalid mask and overflow / underflow detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wim_r <= `WRF_WIM_RESET;
    else if (idle && ctl.wimWe)
      wim_r <= ctl.data & WIM_IMPL;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end
    else
    begin
      ovf_r <= idle && (cmd.op == WOP_SAVE) && wim_r[cwpDec];
      unf_r <= idle && isRest && wim_r[cwpInc];
    end
  end

  assign rdDataA       = rdA_r;
  assign rdDataB       = rdB_r;
  assign psrWord       = {27'h000_0000, cwp_r};
  assign wimWord       = wim_r;
  assign evt.overflow  = ovf_r;
  assign evt.underflow = unf_r;
  assign evt.busy      = busy_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_trapTaken;
    idle && cmd.op == WOP_TRAP;
  endsequence

  sequence s_trapTail;
    busy_r && state_r == ST_TRAP_NPC && wrEnSel &&
    wrNumSel == 5'(`WRF_REG_TRAP_NPC) ##1 !busy_r && idle;
  endsequence

  property p_saveMove;
    @(posedge ref_clk) disable iff (!rst_n)
    saveOk |=> cwp_r == $past(cwpDec) && !ovf_r;
  endproperty
  a_saveMove: assert property (p_saveMove)
    else $error("save did not decrement window pointer");
  property p_saveOvf;
    @(posedge ref_clk) disable iff (!rst_n)
    idle && cmd.op == WOP_SAVE && wim_r[cwpDec] |=> ovf_r && $stable(cwp_r);
  endproperty
  a_saveOvf: assert property (p_saveOvf)
    else $error("masked save did not raise overflow");
  property p_restUnf;
    @(posedge ref_clk) disable iff (!rst_n)
    idle && isRest && wim_r[cwpInc] |=> unf_r && $stable(cwp_r);
  endproperty
  a_restUnf: assert property (p_restUnf)
    else $error("masked restore did not raise underflow");
  property p_restMove;
    @(posedge ref_clk) disable iff (!rst_n)
    restOk |=> cwp_r == $past(cwpInc) && !unf_r;
  endproperty
  a_restMove: assert property (p_restMove)
    else $error("restore did not increment window pointer");
  property p_trapSeq;
    @(posedge ref_clk) disable iff (!rst_n)
    s_trapTaken |-> wrEnSel && wrCwpSel == cwpDec ##1
      (cwp_r == $past(cwpDec)) ##0 s_trapTail;
  endproperty
  a_trapSeq: assert property (p_trapSeq)
    else $error("trap store sequence wrong");
  property p_zeroRead;
    @(posedge ref_clk) disable iff (!rst_n)
    rdNumA == 5'h00 |=> rdDataA == 32'h0000_0000;
  endproperty
  a_zeroRead: assert property (p_zeroRead)
    else $error("register zero read not zero");
  // a plain pipeline write is taken unless it names register zero
  property p_noZeroWrite;
    @(posedge ref_clk) disable iff (!rst_n)
    idle && cmd.op == WOP_NONE && wrReq.en |->
      wrEnSel == (wrReq.num != 5'h00);
  endproperty
  a_noZeroWrite: assert property (p_noZeroWrite)
    else $error("write to register zero not refused");
  property p_call;
    @(posedge ref_clk) disable iff (!rst_n)
    idle && cmd.op == WOP_CALL |-> wrEnSel && wrDataSel == cmd.pc &&
      wrNumSel == 5'(`WRF_REG_CALL_LINK) ##1 $stable(cwp_r);
  endproperty
  a_call: assert property (p_call)
    else $error("call link write wrong");
  property p_cwpRange;
    @(posedge ref_clk) disable iff (!rst_n)
    int'(cwp_r) < NWIN && psrWord[31:5] == 27'h000_0000;
  endproperty
  a_cwpRange: assert property (p_cwpRange)
    else $error("window pointer out of range");
  property p_wimImpl;
    @(posedge ref_clk) disable iff (!rst_n)
    (wim_r & ~WIM_IMPL) == 32'h0000_0000;
  endproperty
  a_wimImpl: assert property (p_wimImpl)
    else $error("mask holds unimplemented window bits");

endmodule
`default_nettype wire

/* File: bench/wrf_pipe_model.sv */
// pipeline model that issues reads, writes and window commands
`timescale 1ns/1ps
`default_nettype none

module wrf_pipe_model (
  input  wire logic         ref_clk, // processor clock
  output logic [4:0]        rdNumA,  // first source number
  output logic [4:0]        rdNumB,  // second source number
  output wrf_pkg::wrf_wr_t  wrReq,   // destination write
  output wrf_pkg::wrf_cmd_t cmd,     // window command
  output wrf_pkg::wrf_ctl_t ctl      // mask and pointer writes
);
  import wrf_pkg::*;

  initial
  begin
    rdNumA = 5'h00;
    rdNumB = 5'h00;
    wrReq  = '0;
    cmd    = '0;
    ctl    = '0;
  end

  // one request per cycle, launched on the falling edge; an idle write
  // port shows flipped data so a stale value never passes for a fresh one
  task automatic issue(
    input logic [4:0] a,
    input logic [4:0] b,
    input wrf_wr_t    w,
    input wrf_cmd_t   c,
    input wrf_ctl_t   t
  );
    wrf_wr_t wNew;
    @(negedge ref_clk);
    wNew = w;
    if (!w.en)
      wNew.data = ~wrReq.data;
    rdNumA = a;
    rdNumB = b;
    wrReq  = wNew;
    cmd    = c;
    ctl    = t;
  endtask
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the windowed register file
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import wrf_pkg::*;

  localparam int       NW    = 8;
  localparam wrf_wr_t  NOWR  = '0;
  localparam wrf_cmd_t NOCMD = '0;
  localparam wrf_ctl_t NOCTL = '0;

  logic        ref_clk;
  logic        rst_n;
  logic [4:0]  rdNumA;
  logic [4:0]  rdNumB;
  wrf_wr_t     wrReq;
  wrf_cmd_t    cmd;
  wrf_ctl_t    ctl;
  logic [31:0] rdDataA;
  logic [31:0] rdDataB;
  logic [31:0] psrWord;
  logic [31:0] wimWord;
  wrf_evt_t    evt;
  int          miscompares = 0;
  int          checksDone  = 0;
  int          cycles      = 0;

  // ----------------------------------------------------------------
  // design and pipeline model
  // ----------------------------------------------------------------
  wrf_regfile #(.NWIN(NW)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .rdNumA(rdNumA), .rdNumB(rdNumB),
    .wrReq(wrReq), .cmd(cmd), .ctl(ctl), .rdDataA(rdDataA),
    .rdDataB(rdDataB), .psrWord(psrWord), .wimWord(wimWord), .evt(evt)
  );

  wrf_pipe_model pipe (
    .ref_clk(ref_clk), .rdNumA(rdNumA), .rdNumB(rdNumB),
    .wrReq(wrReq), .cmd(cmd), .ctl(ctl)
  );

  initial
    ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // a hang is cut well past the roughly sixty cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("[FAIL] %0t ns: run timed out", $time);
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic idle();
    pipe.issue(5'h00, 5'h00, NOWR, NOCMD, NOCTL);
  endtask

  task automatic wr(input logic [4:0] n, input logic [31:0] d);
    pipe.issue(5'h00, 5'h00, '{1'b1, n, d}, NOCMD, NOCTL);
  endtask

  // read data lands one edge after the numbers are taken
  task automatic rd(input logic [4:0] a, input logic [31:0] ea,
                    input logic [4:0] b, input logic [31:0] eb);
    pipe.issue(a, b, NOWR, NOCMD, NOCTL);
    idle();
    chk(rdDataA, ea);
    chk(rdDataB, eb);
  endtask

  // ev is {overflow, underflow, busy} as seen one edge after the command
  task automatic op(input wrf_op_t o, input logic [31:0] p,
                    input logic [31:0] q, input logic [4:0] ptr,
                    input logic [2:0] ev);
    pipe.issue(5'h00, 5'h00, NOWR, '{o, p, q}, NOCTL);
    idle();
    chk(psrWord, {27'h000_0000, ptr});
    chk({29'h0000_0000, evt}, {29'h0000_0000, ev});
  endtask

  task automatic ctlw(input logic m, input logic s, input logic [31:0] d);
    pipe.issue(5'h00, 5'h00, NOWR, NOCMD, '{m, s, d});
    idle();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic checkReset();
    chk(psrWord, 32'h0000_0000);
    chk(wimWord, 32'h0000_0000);
  endtask

  task automatic checkZero();
    wr(5'h01, 32'h1111_2222);
    wr(5'h00, 32'hDEAD_BEEF);
    rd(5'h00, 32'h0000_0000, 5'h01, 32'h1111_2222);
  endtask

  task automatic checkWindows();
    wr(5'h11, 32'hA0A0_0000);
    wr(5'h09, 32'h0B0B_0009);
    op(WOP_SAVE, 32'h0000_0000, 32'h0000_0000, 5'h07, 3'h0);
    rd(5'h01, 32'h1111_2222, 5'h19, 32'h0B0B_0009);
    wr(5'h11, 32'hA7A7_0007);
    wr(5'h1E, 32'hC0C0_001E);
    op(WOP_RESTORE, 32'h0000_0000, 32'h0000_0000, 5'h00, 3'h0);
    rd(5'h11, 32'hA0A0_0000, 5'h0E, 32'hC0C0_001E);
    op(WOP_SAVE, 32'h0000_0000, 32'h0000_0000, 5'h07, 3'h0);
    rd(5'h11, 32'hA7A7_0007, 5'h01, 32'h1111_2222);
    op(WOP_RESTORE, 32'h0000_0000, 32'h0000_0000, 5'h00, 3'h0);
  endtask

  task automatic checkMask();
    ctlw(1'b1, 1'b0, 32'hFFFF_FFFF);
    chk(wimWord, 32'h0000_00FF);
    ctlw(1'b1, 1'b0, 32'h0000_0080);
    op(WOP_SAVE, 32'h0000_0000, 32'h0000_0000, 5'h00, 3'h4);
    ctlw(1'b0, 1'b1, 32'h0000_0008);
    chk(psrWord, 32'h0000_0000);
    ctlw(1'b0, 1'b1, 32'h0000_0006);
    chk(psrWord, 32'h0000_0006);
    op(WOP_RESTORE, 32'h0000_0000, 32'h0000_0000, 5'h06, 3'h2);
    op(WOP_RETURN_FROM_TRAP, 32'h0000_0000, 32'h0000_0000, 5'h06, 3'h2);
    ctlw(1'b1, 1'b0, 32'h0000_0000);
    op(WOP_RETURN_FROM_TRAP, 32'h0000_0000, 32'h0000_0000, 5'h07, 3'h0);
  endtask

  task automatic checkCall();
    op(WOP_CALL, 32'h0000_4A40, 32'h0000_0000, 5'h07, 3'h0);
    rd(5'h0F, 32'h0000_4A40, 5'h00, 32'h0000_0000);
  endtask

  task automatic checkTrap();
    // the trap moves onto a masked window without any overflow
    ctlw(1'b1, 1'b0, 32'h0000_0040);
    op(WOP_TRAP, 32'h0000_1000, 32'h0000_1004, 5'h06, 3'h1);
    rd(5'h11, 32'h0000_1000, 5'h12, 32'h0000_1004);
    chk({29'h0000_0000, evt}, 32'h0000_0000);
    op(WOP_RESTORE, 32'h0000_0000, 32'h0000_0000, 5'h07, 3'h0);
    rd(5'h0F, 32'h0000_4A40, 5'h11, 32'hA7A7_0007);
  endtask

  // a write and a save offered in the busy cycle after a trap are ignored
  task automatic checkBusy();
    pipe.issue(5'h00, 5'h00, NOWR,
               '{WOP_TRAP, 32'h0000_2000, 32'h0000_2004}, NOCTL);
    pipe.issue(5'h00, 5'h00, '{1'b1, 5'h11, 32'h0000_BAD0},
               '{WOP_SAVE, 32'h0000_0000, 32'h0000_0000}, NOCTL);
    idle();
    chk(psrWord, 32'h0000_0006);
    rd(5'h11, 32'h0000_2000, 5'h12, 32'h0000_2004);
  endtask

  initial
  begin
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    checkReset();
    checkZero();
    checkWindows();
    checkMask();
    checkCall();
    checkTrap();
    checkBusy();
    conclude();
  end
endmodule

`default_nettype wire
